//--- page_walk.sv
// Two-level page walker: directory entry, then table entry.
// Assumes the controller holds lin and dir_base steady during a walk.
`default_nettype none
module page_walk (
   // Clock and reset.
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Controller side.
   walk_if.walker w
);
   import seg_xlate_pkg::*;
   typedef enum logic [1:0] {
      W_IDLE = 2'b00,
      W_DIR = 2'b01,
      W_TBL = 2'b10
   } wst_t;
   wst_t st_r;
   wst_t st_nxt;
   logic [31:0] addr_nxt;
   logic present;
   logic [31:0] dir_addr;
   logic [31:0] tbl_addr;

   // Entry addresses from the linear address fields.
   assign present = w.rdata[ENTRY_P_BIT];
   assign dir_addr = {w.dir_base[31:PAGE_OFS_BITS], w.lin[31:PD_IDX_LSB], ENTRY_ALIGN};
   assign tbl_addr = {w.rdata[31:PAGE_OFS_BITS], w.lin[PD_IDX_LSB-1:PAGE_OFS_BITS], ENTRY_ALIGN};
   assign w.rd = (st_r != W_IDLE);

   // Next state of the walk.
   always_comb begin
      st_nxt = st_r;
      addr_nxt = w.addr;
      unique case (st_r)
         W_IDLE: begin
            if (w.start) begin
               st_nxt = W_DIR;
               addr_nxt = dir_addr;
            end
         end
         W_DIR: begin
            if (w.ack) begin
               st_nxt = present ? W_TBL : W_IDLE;
               addr_nxt = tbl_addr;
            end
         end
         W_TBL: begin
            if (w.ack) begin
               st_nxt = W_IDLE;
            end
         end
         default: st_nxt = W_IDLE;
      endcase
   end

   // State and address registers.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         st_r <= W_IDLE;
         w.addr <= 32'h0000_0000;
      end else begin
         st_r <= st_nxt;
         w.addr <= addr_nxt;
      end
   end

   // Result: a missing entry at either level ends the walk with a fault.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         w.done <= 1'b0;
         w.fault <= 1'b0;
         w.phys <= 32'h0000_0000;
      end else begin
         w.done <= w.ack && ((st_r == W_TBL) || (st_r == W_DIR && !present));
         w.fault <= w.ack && !present;
         w.phys <= {w.rdata[31:PAGE_OFS_BITS], w.lin[PAGE_OFS_BITS-1:0]};
      end
   end
endmodule
`default_nettype wire

//--- seg_check.sv
// Combinational descriptor decode and segment access check.
// Assumes the two descriptor words are stable while the result is used.
`default_nettype none
module seg_check (
   // Descriptor and request.
   input wire logic [31:0] lo_i,
   input wire logic [31:0] hi_i,
   input wire logic [31:0] off_i,
   input wire seg_xlate_pkg::acc_kind_t kind_i,
   input wire logic [1:0] cpl_i,
   input wire logic [1:0] rpl_i,
   input wire logic long_mode_i,
   // Result.
   output logic [31:0] base_o,
   output logic [31:0] limit_o,
   output logic [31:0] lin_o,
   output logic ok_o
);
   import seg_xlate_pkg::*;
   logic [19:0] lim20;
   logic [1:0] dpl;
   logic [1:0] eff_pl;
   logic is_code;
   logic rw;
   logic type_ok;
   logic priv_ok;
   logic limit_ok;

   // Field extraction; granular limits fill the low 12 bits with ones.
   assign lim20 = {hi_i[D_LIM_MSB:D_LIM_LSB], lo_i[D_LIM_LOW_MSB:0]};
   assign base_o = {hi_i[D_BASE_TOP_MSB:D_BASE_TOP_LSB], hi_i[D_BASE_MID_MSB:0],
                    lo_i[31:D_BASE_LOW_LSB]};
   assign limit_o = hi_i[D_G_BIT] ? {lim20, LIMIT_FILL} : {12'h000, lim20};
   assign dpl = hi_i[D_DPL_MSB:D_DPL_LSB];
   assign is_code = hi_i[D_CODE_BIT];
   assign rw = hi_i[D_RW_BIT];
   assign eff_pl = (cpl_i > rpl_i) ? cpl_i : rpl_i;

   // Code is never written and data never executed.
   assign type_ok = (kind_i == ACC_EXEC) ? is_code :
                    (kind_i == ACC_WRITE) ? (!is_code && rw) :
                    (!is_code || rw);
   assign priv_ok = (kind_i == ACC_EXEC) ? (cpl_i == dpl) : (eff_pl <= dpl);

   // A 4 GB limit always passes; 64-bit mode skips the limit test.
   assign limit_ok = long_mode_i || (off_i <= limit_o);

   // Overall verdict and the base plus offset sum.
   assign ok_o = hi_i[D_P_BIT] && hi_i[D_S_BIT] && type_ok && priv_ok && limit_ok;
   assign lin_o = base_o + off_i;
endmodule
`default_nettype wire

//--- seg_mem_model.sv
// Far-side model: descriptor and page table memory plus the data memory port.
// Assumes one clock; requests are levels that the translator holds until answered.
`default_nettype none
module seg_mem_model (
   // Clock, reset and pacing.
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic slow_i,
   // Table read port.
   input wire logic tbl_rd_i,
   input wire logic [31:0] tbl_addr_i,
   output logic [31:0] tbl_data_o,
   output logic tbl_ack_o,
   // Memory access port.
   input wire logic acc_valid_i,
   input wire logic acc_write_i,
   input wire logic [31:0] acc_addr_i,
   output logic acc_ready_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem [logic [31:0]];
   int acc_count = 0;
   int tbl_wait = 0;
   int acc_wait = 0;
   logic [31:0] last_addr = 32'h0;
   logic last_write = 1'b0;
   initial begin
      tbl_data_o = 32'h0;
      tbl_ack_o = 1'b0;
      acc_ready_o = 1'b0;
   end
   // Table reads are answered after a delay; outside the ack cycle the data bus is scrambled.
   always @(posedge clk_sys_i) begin
      tbl_ack_o <= 1'b0;
      tbl_data_o <= ~tbl_data_o;
      tbl_wait <= 0;
      if (!rst_i && tbl_rd_i && !tbl_ack_o) begin
         if (tbl_wait >= (slow_i ? 3 : 0)) begin
            tbl_ack_o <= 1'b1;
            tbl_data_o <= mem.exists(tbl_addr_i) ? mem[tbl_addr_i] : 32'h0;
         end else begin
            tbl_wait <= tbl_wait + 1;
         end
      end
   end
   // Memory accesses are accepted after a delay and logged at the handshake edge.
   always @(posedge clk_sys_i) begin
      acc_ready_o <= 1'b0;
      acc_wait <= 0;
      if (acc_valid_i && acc_ready_o) begin
         acc_count <= acc_count + 1;
         last_addr <= acc_addr_i;
         last_write <= acc_write_i;
      end
      if (!rst_i && acc_valid_i && !acc_ready_o) begin
         if (acc_wait >= (slow_i ? 2 : 0)) begin
            acc_ready_o <= 1'b1;
         end else begin
            acc_wait <= acc_wait + 1;
         end
      end
   end
endmodule
`default_nettype wire

//--- seg_xlate.sv
// Segment translation front end: selector and offset in, checked access out.
// Assumes the core, the table read port and the memory share clk_sys_i.
`default_nettype none
module seg_xlate (
   // Clock and reset.
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Requests from the execution core.
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic [15:0] req_sel_i,
   input wire logic [31:0] req_off_i,
   input wire seg_xlate_pkg::acc_kind_t req_kind_i,
   input wire logic req_use_dseg_i,
   // Processor mode and table bases.
   input wire logic [1:0] cpl_i,
   input wire logic paging_en_i,
   input wire logic long_mode_i,
   input wire logic [31:0] gtab_base_i,
   input wire logic [31:0] ltab_base_i,
   input wire logic [31:0] page_dir_base_i,
   // Completion report.
   output logic done_o,
   output logic gp_fault_o,
   output logic pf_fault_o,
   output logic [31:0] lin_addr_o,
   output logic [31:0] phys_addr_o,
   // Descriptor and page table reads.
   output logic tbl_rd_o,
   output logic [31:0] tbl_addr_o,
   input wire logic [31:0] tbl_data_i,
   input wire logic tbl_ack_i,
   // Memory access.
   output logic acc_valid_o,
   output logic acc_write_o,
   output logic [31:0] acc_addr_o,
   input wire logic acc_ready_i
);
   import seg_xlate_pkg::*;

   typedef enum logic [2:0] {
      ST_BOOT = 3'b000,
      ST_IDLE = 3'b001,
      ST_DLO = 3'b010,
      ST_DHI = 3'b011,
      ST_CHECK = 3'b100,
      ST_WALK = 3'b101,
      ST_ACCESS = 3'b110,
      ST_REPORT = 3'b111
   } st_t;

   // Descriptor address from a selector: bit 2 picks the table.
   function automatic logic [31:0] desc_addr(input logic [15:0] sel, input logic [31:0] gtab,
                                             input logic [31:0] ltab);
      logic [31:0] tbase;
      tbase = sel[SEL_TBL_BIT] ? ltab : gtab;
      desc_addr = tbase + {16'h0000, sel & SEL_IDX_MASK};
   endfunction

   st_t state_r;
   st_t state_nxt;
   fault_t fault_r;
   fault_t fault_nxt;
   logic [15:0] sel_r;
   logic [31:0] off_r;
   acc_kind_t kind_r;
   logic use_dseg_r;
   logic [1:0] cpl_r;
   logic paging_r;
   logic long_r;
   logic [31:0] lo_r;
   logic [31:0] hi_r;
   logic [31:0] dseg_lo_r;
   logic [31:0] dseg_hi_r;
   logic [31:0] lin_r;
   logic [31:0] phys_r;
   logic [31:0] phys_nxt;
   logic boot_r;
   logic wstart_r;
   logic null_sel;
   logic take;
   logic in_desc;
   logic desc_ack;
   logic [31:0] chk_lo;
   logic [31:0] chk_hi;
   logic [31:0] chk_base;
   logic [31:0] chk_limit;
   logic [31:0] chk_lin;
   logic chk_ok;
   logic [31:0] cur_desc;

   walk_if w ();

   // Descriptor checker on either the fetched words or the data segment register.
   assign chk_lo = (use_dseg_r && kind_r != ACC_LOAD_DSEG) ? dseg_lo_r : lo_r;
   assign chk_hi = (use_dseg_r && kind_r != ACC_LOAD_DSEG) ? dseg_hi_r : hi_r;

   seg_check u_check (
      .lo_i(chk_lo),
      .hi_i(chk_hi),
      .off_i(off_r),
      .kind_i(kind_r),
      .cpl_i(cpl_r),
      .rpl_i(sel_r[SEL_RPL_MSB:0]),
      .long_mode_i(long_r),
      .base_o(chk_base),
      .limit_o(chk_limit),
      .lin_o(chk_lin),
      .ok_o(chk_ok)
   );

   page_walk u_walk (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .w(w)
   );

   // Walker hookup; it is started only for linear addresses that passed the checks.
   assign w.start = wstart_r;
   assign w.lin = lin_r;
   assign w.dir_base = page_dir_base_i;
   assign w.rdata = tbl_data_i;
   assign w.ack = tbl_ack_i && w.rd;

   // Request acceptance, table port sharing and outputs.
   assign req_ready_o = (state_r == ST_IDLE);
   assign take = req_valid_i && req_ready_o;
   assign null_sel = ((req_sel_i & SEL_IDX_MASK) == 16'h0000) && !req_sel_i[SEL_TBL_BIT];
   assign in_desc = (state_r == ST_DLO) || (state_r == ST_DHI);
   assign desc_ack = in_desc && tbl_ack_i;
   assign cur_desc = desc_addr(sel_r, gtab_base_i, ltab_base_i);
   assign tbl_rd_o = in_desc || w.rd;
   assign tbl_addr_o = (state_r == ST_DLO) ? cur_desc :
                       (state_r == ST_DHI) ? cur_desc + DESC_HI_OFS : w.addr;
   assign acc_valid_o = (state_r == ST_ACCESS);
   assign acc_write_o = (kind_r == ACC_WRITE) && !boot_r;
   assign acc_addr_o = phys_r;
   assign phys_addr_o = phys_r;
   assign lin_addr_o = lin_r;
   assign done_o = (state_r == ST_REPORT);
   assign gp_fault_o = done_o && (fault_r == FLT_GP);
   assign pf_fault_o = done_o && (fault_r == FLT_PF);

   // Sequencer: fetch, check, optional walk, access, report.
   always_comb begin
      state_nxt = state_r;
      fault_nxt = fault_r;
      phys_nxt = phys_r;
      unique case (state_r)
         ST_BOOT: begin
            state_nxt = ST_ACCESS;
            phys_nxt = RESET_FETCH_ADDR;
         end
         ST_IDLE: begin
            fault_nxt = FLT_NONE;
            if (take) begin
               if (req_use_dseg_i && req_kind_i != ACC_LOAD_DSEG) begin
                  state_nxt = ST_CHECK;
               end else if (null_sel) begin
                  state_nxt = ST_REPORT;
                  fault_nxt = FLT_GP;
               end else begin
                  state_nxt = ST_DLO;
               end
            end
         end
         ST_DLO: begin
            if (desc_ack) begin
               state_nxt = ST_DHI;
            end
         end
         ST_DHI: begin
            if (desc_ack) begin
               state_nxt = ST_CHECK;
            end
         end
         ST_CHECK: begin
            if (!chk_ok) begin
               state_nxt = ST_REPORT;
               fault_nxt = FLT_GP;
            end else if (kind_r == ACC_LOAD_DSEG) begin
               state_nxt = ST_REPORT;
            end else if (paging_r) begin
               state_nxt = ST_WALK;
            end else begin
               state_nxt = ST_ACCESS;
               phys_nxt = chk_lin;
            end
         end
         ST_WALK: begin
            if (w.done) begin
               state_nxt = w.fault ? ST_REPORT : ST_ACCESS;
               fault_nxt = w.fault ? FLT_PF : FLT_NONE;
               phys_nxt = w.phys;
            end
         end
         ST_ACCESS: begin
            if (acc_ready_i) begin
               state_nxt = boot_r ? ST_IDLE : ST_REPORT;
            end
         end
         ST_REPORT: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Control state.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state_r <= ST_BOOT;
         fault_r <= FLT_NONE;
         phys_r <= RESET_FETCH_ADDR;
         boot_r <= 1'b1;
         wstart_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         fault_r <= fault_nxt;
         phys_r <= phys_nxt;
         boot_r <= boot_r && !(state_r == ST_ACCESS && acc_ready_i);
         wstart_r <= (state_r == ST_CHECK) && (state_nxt == ST_WALK);
      end
   end

   // Request capture; mode inputs are frozen for the whole access.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         sel_r <= 16'h0000;
         off_r <= 32'h0000_0000;
         kind_r <= ACC_READ;
         use_dseg_r <= 1'b0;
         cpl_r <= 2'b00;
         paging_r <= 1'b0;
         long_r <= 1'b0;
      end else if (take) begin
         sel_r <= req_sel_i;
         off_r <= req_off_i;
         kind_r <= req_kind_i;
         use_dseg_r <= req_use_dseg_i;
         cpl_r <= cpl_i;
         paging_r <= paging_en_i;
         long_r <= long_mode_i;
      end
   end

   // Descriptor words from the table port.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         lo_r <= 32'h0000_0000;
         hi_r <= 32'h0000_0000;
      end else if (desc_ack) begin
         if (state_r == ST_DLO) begin
            lo_r <= tbl_data_i;
         end else begin
            hi_r <= tbl_data_i;
         end
      end
   end

   // Linear address and data segment register; the latter resets to a flat segment.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         lin_r <= 32'h0000_0000;
         dseg_lo_r <= DSEG_RESET_LO;
         dseg_hi_r <= DSEG_RESET_HI;
      end else if (state_r == ST_CHECK) begin
         lin_r <= chk_lin;
         if (chk_ok && kind_r == ACC_LOAD_DSEG) begin
            dseg_lo_r <= lo_r;
            dseg_hi_r <= hi_r;
         end
      end
   end

   // Checks on the sequencer.
   a_boot_fetch_addr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $past(rst_i) |=> acc_valid_o && acc_addr_o == RESET_FETCH_ADDR && !acc_write_o)
      else $error("first access after reset is not the reset fetch");
   a_dseg_flat_base: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $past(rst_i) |-> {dseg_hi_r[D_BASE_TOP_MSB:D_BASE_TOP_LSB], dseg_hi_r[D_BASE_MID_MSB:0],
                        dseg_lo_r[31:D_BASE_LOW_LSB]} == 32'h0000_0000)
      else $error("data segment base not zero after reset");
   a_desc_fetch_addr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      state_r == ST_DLO && tbl_rd_o |-> tbl_addr_o ==
         (sel_r[SEL_TBL_BIT] ? ltab_base_i : gtab_base_i) + {16'h0000, sel_r[15:3], 3'b000})
      else $error("descriptor read address wrong");
   a_limit_gp: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      state_r == ST_CHECK && !long_r && off_r > chk_limit |=> gp_fault_o ##1 state_r == ST_IDLE)
      else $error("out of limit access not faulted");
   a_lin_sum: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      state_r == ST_CHECK |=> lin_r == $past(chk_base) + $past(off_r))
      else $error("linear address is not base plus offset");
   a_flat_passthru: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      acc_valid_o && !boot_r && !paging_r |-> acc_addr_o == lin_r)
      else $error("unpaged access address differs from linear");
   a_fault_no_access: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      state_r == ST_CHECK && !chk_ok |=> (!acc_valid_o && !w.start) [*2])
      else $error("faulting access reached memory or paging");
   a_page_fault: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      state_r == ST_WALK && w.done && w.fault |=> pf_fault_o && !gp_fault_o && !acc_valid_o)
      else $error("missing page not reported as page fault");
   a_one_fault: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      gp_fault_o |-> !pf_fault_o && !$past(w.start))
      else $error("more than one fault for one access");
   a_write_code: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      state_r == ST_CHECK && kind_r == ACC_WRITE && chk_hi[D_CODE_BIT] |=> gp_fault_o)
      else $error("write to code segment not rejected");
endmodule
`default_nettype wire

//--- seg_xlate_pkg.sv
// Constants and types shared by the segment translation front end.
// Assumes 32-bit linear and physical addresses and 32-bit table reads.
`default_nettype none
package seg_xlate_pkg;
   // Reset state of fetch and of the data segment register.
   localparam logic [31:0] RESET_FETCH_ADDR = 32'hFFFF_FFF0;
   localparam logic [31:0] DSEG_RESET_LO = 32'h0000_FFFF; // Base 0, limit low.
   localparam logic [31:0] DSEG_RESET_HI = 32'h00CF_9300; // Data, writable, 4 GB.
   // Selector layout.
   localparam logic [15:0] SEL_IDX_MASK = 16'hFFF8; // Index times 8.
   localparam int SEL_TBL_BIT = 2;
   localparam int SEL_RPL_MSB = 1;
   localparam logic [31:0] DESC_HI_OFS = 32'h0000_0004;
   // Descriptor high word fields.
   localparam int D_BASE_TOP_MSB = 31;
   localparam int D_BASE_TOP_LSB = 24;
   localparam int D_G_BIT = 23;
   localparam int D_LIM_MSB = 19;
   localparam int D_LIM_LSB = 16;
   localparam int D_P_BIT = 15;
   localparam int D_DPL_MSB = 14;
   localparam int D_DPL_LSB = 13;
   localparam int D_S_BIT = 12;
   localparam int D_CODE_BIT = 11;
   localparam int D_RW_BIT = 9;
   localparam int D_BASE_MID_MSB = 7;
   // Descriptor low word fields.
   localparam int D_BASE_LOW_LSB = 16;
   localparam int D_LIM_LOW_MSB = 15;
   localparam logic [11:0] LIMIT_FILL = 12'hFFF;
   // Paging layout with 4 KB pages.
   localparam int PAGE_BYTES = 4096;
   localparam int PAGE_OFS_BITS = $clog2(PAGE_BYTES);
   localparam int PD_IDX_LSB = 22;
   localparam int ENTRY_P_BIT = 0;
   localparam logic [1:0] ENTRY_ALIGN = 2'b00;
   // Kinds of request and of fault.
   typedef enum logic [1:0] {
      ACC_READ = 2'b00,
      ACC_WRITE = 2'b01,
      ACC_EXEC = 2'b10,
      ACC_LOAD_DSEG = 2'b11
   } acc_kind_t;
   typedef enum logic [1:0] {
      FLT_NONE = 2'b00,
      FLT_GP = 2'b01,
      FLT_PF = 2'b10
   } fault_t;
endpackage
`default_nettype wire

//--- segment_address_translation_test.sv
// Self-checking bench for the segment translation front end.
// Assumes seg_xlate, its package and seg_mem_model are compiled before it.
`default_nettype none
module segment_address_translation_test;
   timeunit 1ns;
   timeprecision 1ns;
   import seg_xlate_pkg::*;
   typedef struct {
      logic [15:0] sel;
      logic [31:0] off;
      acc_kind_t kind;
      logic [2:0] mode;
      logic [1:0] cpl;
      fault_t flt;
      logic [31:0] lin;
   } row_t;
   logic clk_sys_i, rst_i, req_valid_i, req_ready_o, req_use_dseg_i, paging_en_i, long_mode_i, slow;
   logic [15:0] req_sel_i;
   logic [31:0] req_off_i, gtab_base_i, ltab_base_i, page_dir_base_i, lin_addr_o, phys_addr_o;
   logic [31:0] tbl_addr_o, tbl_data_i, acc_addr_o;
   acc_kind_t req_kind_i;
   logic [1:0] cpl_i;
   logic done_o, gp_fault_o, pf_fault_o, tbl_rd_o, tbl_ack_i, acc_valid_o, acc_write_o, acc_ready_i;
   int fail_count = 0;
   int checks_done = 0;
   int cycles = 0;
   row_t rows [20];
   seg_xlate uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
      .req_sel_i(req_sel_i), .req_off_i(req_off_i), .req_kind_i(req_kind_i), .req_use_dseg_i(req_use_dseg_i),
      .cpl_i(cpl_i), .paging_en_i(paging_en_i), .long_mode_i(long_mode_i), .gtab_base_i(gtab_base_i),
      .ltab_base_i(ltab_base_i), .page_dir_base_i(page_dir_base_i), .done_o(done_o), .gp_fault_o(gp_fault_o),
      .pf_fault_o(pf_fault_o), .lin_addr_o(lin_addr_o), .phys_addr_o(phys_addr_o), .tbl_rd_o(tbl_rd_o),
      .tbl_addr_o(tbl_addr_o), .tbl_data_i(tbl_data_i), .tbl_ack_i(tbl_ack_i), .acc_valid_o(acc_valid_o),
      .acc_write_o(acc_write_o), .acc_addr_o(acc_addr_o), .acc_ready_i(acc_ready_i));
   seg_mem_model far (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .slow_i(slow), .tbl_rd_i(tbl_rd_o),
      .tbl_addr_i(tbl_addr_o), .tbl_data_o(tbl_data_i), .tbl_ack_o(tbl_ack_i), .acc_valid_i(acc_valid_o),
      .acc_write_i(acc_write_o), .acc_addr_i(acc_addr_o), .acc_ready_o(acc_ready_i));
   // Clock generation at 100 ns period.
   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   // Prints the verdict and ends the run.
   task automatic close_out();
      if (fail_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Single-bit and word comparisons.
   task automatic chk1(input logic got, input logic exp, input string what);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Reset for 16 cycles, then expect the boot fetch on the memory port.
   task automatic do_reset();
      int n0;
      int k;
      n0 = far.acc_count;
      rst_i <= 1'b1;
      repeat (16) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      k = 0;
      do begin
         @(posedge clk_sys_i);
         k++;
      end while (far.acc_count == n0 && k < 50);
      chk32(far.last_addr, 32'hFFFF_FFF0, "boot fetch address");
      chk1(far.last_write, 1'b0, "boot fetch is a read");
   endtask
   // Issues one request, waits for completion and checks flags and access count; addresses only when an access is expected.
   task automatic run_row(input row_t r);
      int n0;
      int k;
      logic acc;
      logic [31:0] phys;
      n0 = far.acc_count;
      acc = (r.flt == FLT_NONE) && (r.kind != ACC_LOAD_DSEG);
      phys = r.mode[1] ? {20'h00098, r.lin[11:0]} : r.lin;
      @(posedge clk_sys_i);
      req_valid_i <= 1'b1;
      req_sel_i <= r.sel;
      req_off_i <= r.off;
      req_kind_i <= r.kind;
      {req_use_dseg_i, paging_en_i, long_mode_i} <= r.mode;
      cpl_i <= r.cpl;
      k = 0;
      do begin
         @(posedge clk_sys_i);
         k++;
      end while (req_ready_o !== 1'b1 && k < 100);
      req_valid_i <= 1'b0;
      do begin
         @(posedge clk_sys_i);
         k++;
      end while (done_o !== 1'b1 && k < 200);
      chk1(done_o, 1'b1, "completion");
      chk1(gp_fault_o, r.flt == FLT_GP, "protection fault");
      chk1(pf_fault_o, r.flt == FLT_PF, "page fault");
      chk32(32'(far.acc_count - n0), {31'h0, acc}, "memory accesses");
      if (acc) begin
         chk32(lin_addr_o, r.lin, "linear address");
         chk32(far.last_addr, phys, "bus address");
         chk32(phys_addr_o, phys, "physical address");
         chk1(far.last_write, r.kind == ACC_WRITE, "write flag");
      end
   endtask
   // Cuts a hang short.
   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count++;
         close_out();
      end
   end
   // Main sequence: table rows, then a mid-run reset and the data segment after it.
   initial begin
      rst_i = 1'b1;
      req_valid_i = 1'b0;
      req_sel_i = 16'h0;
      req_off_i = 32'h0;
      req_kind_i = ACC_READ;
      {req_use_dseg_i, paging_en_i, long_mode_i} = 3'h0;
      cpl_i = 2'h0;
      slow = 1'b0;
      gtab_base_i = 32'h0000_1000;
      ltab_base_i = 32'h0000_2000;
      page_dir_base_i = 32'h0000_3000;
      far.mem[32'h0000_1008] = 32'h0000_0FFF;
      far.mem[32'h0000_100C] = 32'h0000_9201;
      far.mem[32'h0000_1010] = 32'h0000_FFFF;
      far.mem[32'h0000_1014] = 32'h00CF_9A00;
      far.mem[32'h0000_1018] = 32'h0000_FFFF;
      far.mem[32'h0000_101C] = 32'h0000_1200;
      far.mem[32'h0000_2008] = 32'h0000_00FF;
      far.mem[32'h0000_200C] = 32'h0000_9020;
      far.mem[32'h0000_3000] = 32'h0000_4001;
      far.mem[32'h0000_4040] = 32'h0009_8001;
      rows = '{
         '{16'h0008, 32'h0000_0010, ACC_READ, 3'h0, 2'h0, FLT_NONE, 32'h0001_0010},
         '{16'h0008, 32'h0000_0FFF, ACC_WRITE, 3'h0, 2'h0, FLT_NONE, 32'h0001_0FFF},
         '{16'h0008, 32'h0000_1000, ACC_READ, 3'h0, 2'h0, FLT_GP, 32'h0},
         '{16'h0010, 32'h0000_0040, ACC_EXEC, 3'h0, 2'h0, FLT_NONE, 32'h0000_0040},
         '{16'h0010, 32'h0000_0040, ACC_WRITE, 3'h0, 2'h0, FLT_GP, 32'h0},
         '{16'h0008, 32'h0000_0000, ACC_EXEC, 3'h0, 2'h0, FLT_GP, 32'h0},
         '{16'h000C, 32'h0000_0004, ACC_READ, 3'h0, 2'h0, FLT_NONE, 32'h0020_0004},
         '{16'h000C, 32'h0000_0004, ACC_WRITE, 3'h0, 2'h0, FLT_GP, 32'h0},
         '{16'h0000, 32'h0000_0000, ACC_READ, 3'h0, 2'h0, FLT_GP, 32'h0},
         '{16'h0018, 32'h0000_0000, ACC_READ, 3'h0, 2'h0, FLT_GP, 32'h0},
         '{16'h0000, 32'hFFFF_FFFC, ACC_READ, 3'h4, 2'h0, FLT_NONE, 32'hFFFF_FFFC},
         '{16'h0008, 32'h0000_5000, ACC_READ, 3'h1, 2'h0, FLT_NONE, 32'h0001_5000},
         '{16'h0008, 32'h0000_0010, ACC_READ, 3'h0, 2'h3, FLT_GP, 32'h0},
         '{16'h0008, 32'h0000_0010, ACC_READ, 3'h2, 2'h0, FLT_NONE, 32'h0001_0010},
         '{16'h0000, 32'h0040_0000, ACC_READ, 3'h6, 2'h0, FLT_PF, 32'h0},
         '{16'h0008, 32'h0000_1000, ACC_READ, 3'h2, 2'h0, FLT_GP, 32'h0},
         '{16'h000C, 32'h0000_0000, ACC_LOAD_DSEG, 3'h0, 2'h0, FLT_NONE, 32'h0},
         '{16'h0000, 32'h0000_0100, ACC_READ, 3'h4, 2'h0, FLT_GP, 32'h0},
         '{16'h0000, 32'h0000_0010, ACC_WRITE, 3'h4, 2'h0, FLT_GP, 32'h0},
         '{16'h0000, 32'h0000_0010, ACC_READ, 3'h4, 2'h0, FLT_NONE, 32'h0020_0010}};
      do_reset();
      foreach (rows[i]) begin
         slow <= i[0];
         run_row(rows[i]);
      end
      do_reset();
      run_row('{16'h0000, 32'h0000_0010, ACC_READ, 3'h4, 2'h0, FLT_NONE, 32'h0000_0010});
      close_out();
   end
endmodule
`default_nettype wire

//--- walk_if.sv
// Carrier between the translation controller and the page walker.
// Assumes both ends share one clock; rdata and ack come from the table port.
`default_nettype none
interface walk_if;
   logic start;
   logic [31:0] lin;
   logic [31:0] dir_base;
   logic done;
   logic fault;
   logic [31:0] phys;
   logic rd;
   logic [31:0] addr;
   logic [31:0] rdata;
   logic ack;
   modport ctrl (output start, lin, dir_base, rdata, ack, input done, fault, phys, rd, addr);
   modport walker (input start, lin, dir_base, rdata, ack, output done, fault, phys, rd, addr);
endinterface
`default_nettype wire
